// *** verilog/rsa_defs.svh ***
// Offsets, field positions, reset values and codes for strobe assignment
// Notes on behaviour
// - Backup rail six strobe field bits 5-4: 1h strobe 1, 2h strobe 2.
// - Backup rail five strobe field bits 1-0, reset 2h, same codes.
// - Once seal is broken the sequencer never turns off a backup rail.
// - Load switch field bits 7-4, reset Ah, codes 3h-Ah pick strobe 3-10.
// - Linear regulator field bits 3-0, reset 7h, codes 3h-Ah pick strobes.
// - Codes 0h-2h and Bh-Fh leave a load switch or regulator outside sequencer control; backup codes 0h and 3h do so.
`ifndef RSA_DEFS_SVH
`define RSA_DEFS_SVH
`define RSA_IDX_BACKUP 8'h24
`define RSA_IDX_SWREG 8'h25
`define RSA_IDX_UNLOCK 8'h26
`define RSA_IDX_STATUS 8'h27
`define RSA_RST_BACKUP 8'h12
`define RSA_RST_SWREG 8'hA7
`define RSA_BACKUP_MASK 8'h33
`define RSA_R6_HI 5
`define RSA_R6_LO 4
`define RSA_R5_HI 1
`define RSA_R5_LO 0
`define RSA_LS_HI 7
`define RSA_LS_LO 4
`define RSA_LR_HI 3
`define RSA_LR_LO 0
`define RSA_CODE_MIN 4'h3
`define RSA_CODE_MAX 4'hA
`define RSA_CODE_S1 2'h1
`define RSA_CODE_S2 2'h2
`define RSA_UNLOCK_KEY 8'h7D
`endif

// *** verilog/rsa_pkg.sv ***
// Types shared by the strobe assignment block
package rsa_pkg;
	typedef struct packed {
		logic enable;
		logic turn_off;
	} rsa_rail_cmd_s;
	typedef enum logic [1:0] {
		RSA_IDLE = 2'b00,
		RSA_UP = 2'b01,
		RSA_DOWN = 2'b10
	} rsa_dir_e;
endpackage

// *** verilog/rsa_rail_decode.sv ***
// One rail: strobe code match into enable/disable command
`timescale 1ns/100ps
`include "rsa_defs.svh"
module rsa_rail_decode
	import rsa_pkg::*;
#(
	parameter int W = 4,
	parameter bit BACKUP = 1'b0
) (
	input wire logic [W-1:0] code,
	input wire logic [3:0] strobe,
	input wire logic strobe_valid,
	input wire logic up,
	input wire logic seal_broken,
	output rsa_rail_cmd_s cmd
);
	logic hit;
	always_comb begin
		if (BACKUP) begin
			hit = (code == W'(`RSA_CODE_S1) || code == W'(`RSA_CODE_S2)) &&
				(4'(code) == strobe) && !seal_broken;
		end else begin
			hit = (4'(code) >= `RSA_CODE_MIN) &&
				(4'(code) <= `RSA_CODE_MAX) && (4'(code) == strobe);
		end
		cmd.enable = strobe_valid && hit && up;
		// Backup rails must stay on after seal break
		cmd.turn_off = strobe_valid && hit && !up &&
			!(BACKUP && seal_broken);
	end
endmodule

// *** verilog/rsa_top.sv ***
// Strobe assignment registers with APB slave and per-rail decode
`timescale 1ns/100ps
`include "rsa_defs.svh"
module rsa_top
	import rsa_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] strobe,
	input wire logic strobe_valid,
	input wire rsa_dir_e dir,
	input wire logic freshness_seal_flag,
	output logic [3:0] rail_enable,
	output logic [3:0] rail_disable
);
	logic [7:0] backup_rail_strobe_select;
	logic [7:0] switch_regulator_strobe_select;
	logic unlocked;
	logic seal_meta;
	logic seal_sync;
	logic acc;
	logic wr;
	logic hit_backup;
	logic hit_swreg;
	logic hit_unlock;
	logic hit_status;
	logic mapped;
	logic up;
	rsa_rail_cmd_s cmd [4];
	logic first_acc;
	logic wr_done;
	logic key_ok;
	logic wr_backup;
	logic wr_swreg;
	logic next_unlocked;
	logic [7:0] next_backup;
	logic [7:0] next_swreg;
	logic [7:0] next_rdata;
	logic [1:0] seal_status;

	assign acc = psel && penable;
	assign first_acc = acc && !pready;
	assign wr = acc && pwrite && pstrb[0];
	// A write lands at the edge that samples pready high
	assign wr_done = wr && pready;
	assign key_ok = pwdata[7:0] == `RSA_UNLOCK_KEY;
	assign wr_backup = wr_done && unlocked && hit_backup;
	assign wr_swreg = wr_done && unlocked && hit_swreg;
	assign seal_status = {seal_sync, unlocked};
	assign mapped = hit_backup || hit_swreg || hit_unlock || hit_status;
	assign up = dir == RSA_UP;

	// Byte address is four times the register index
	always_comb begin
		hit_backup = 1'b0;
		hit_swreg = 1'b0;
		hit_unlock = 1'b0;
		hit_status = 1'b0;
		case (paddr)
			12'(`RSA_IDX_BACKUP) * 12'h004: hit_backup = 1'b1;
			12'(`RSA_IDX_SWREG) * 12'h004: hit_swreg = 1'b1;
			12'(`RSA_IDX_UNLOCK) * 12'h004: hit_unlock = 1'b1;
			12'(`RSA_IDX_STATUS) * 12'h004: hit_status = 1'b1;
			default: hit_backup = 1'b0;
		endcase
	end

	// Seal flag comes from the backup domain pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seal_meta <= 1'b0;
			seal_sync <= 1'b0;
		end else begin
			seal_meta <= freshness_seal_flag;
			seal_sync <= seal_meta;
		end
	end

	// Unlock lasts for exactly one following register write
	always_comb begin
		next_unlocked = unlocked;
		if (wr_done) begin
			next_unlocked = hit_unlock && key_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlocked <= 1'b0;
		end else begin
			unlocked <= next_unlocked;
		end
	end

	// Fields copied one by one so reserved bits never store
	always_comb begin
		next_backup = backup_rail_strobe_select;
		if (wr_backup) begin
			next_backup[`RSA_R6_HI:`RSA_R6_LO] =
				pwdata[`RSA_R6_HI:`RSA_R6_LO];
			next_backup[`RSA_R5_HI:`RSA_R5_LO] =
				pwdata[`RSA_R5_HI:`RSA_R5_LO];
		end
		next_backup = next_backup & `RSA_BACKUP_MASK;
	end

	always_comb begin
		next_swreg = switch_regulator_strobe_select;
		if (wr_swreg) begin
			next_swreg[`RSA_LS_HI:`RSA_LS_LO] =
				pwdata[`RSA_LS_HI:`RSA_LS_LO];
			next_swreg[`RSA_LR_HI:`RSA_LR_LO] =
				pwdata[`RSA_LR_HI:`RSA_LR_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backup_rail_strobe_select <= `RSA_RST_BACKUP;
		end else begin
			backup_rail_strobe_select <= next_backup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_regulator_strobe_select <= `RSA_RST_SWREG;
		end else begin
			switch_regulator_strobe_select <= next_swreg;
		end
	end

	// Read data chosen in the first access cycle
	always_comb begin
		next_rdata = 8'h00;
		if (first_acc && !pwrite) begin
			if (hit_backup) begin
				next_rdata = backup_rail_strobe_select;
			end else if (hit_swreg) begin
				next_rdata = switch_regulator_strobe_select;
			end else if (hit_status) begin
				next_rdata = {6'h00, seal_status};
			end
		end
	end

	// One wait state keeps read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= first_acc;
			pslverr <= first_acc && !mapped;
			prdata <= {24'h00_0000, next_rdata};
		end
	end

	// Backup rails take two-bit codes; seal gating sits in the decoder
	rsa_rail_decode #(.W(2), .BACKUP(1'b1)) u_rail6 (
		.code(backup_rail_strobe_select[`RSA_R6_HI:`RSA_R6_LO]),
		.strobe(strobe),
		.strobe_valid(strobe_valid),
		.up(up),
		.seal_broken(seal_sync),
		.cmd(cmd[0])
	);

	rsa_rail_decode #(.W(2), .BACKUP(1'b1)) u_rail5 (
		.code(backup_rail_strobe_select[`RSA_R5_HI:`RSA_R5_LO]),
		.strobe(strobe),
		.strobe_valid(strobe_valid),
		.up(up),
		.seal_broken(seal_sync),
		.cmd(cmd[1])
	);

	rsa_rail_decode #(.W(4), .BACKUP(1'b0)) u_ls (
		.code(switch_regulator_strobe_select[`RSA_LS_HI:`RSA_LS_LO]),
		.strobe(strobe),
		.strobe_valid(strobe_valid),
		.up(up),
		.seal_broken(seal_sync),
		.cmd(cmd[2])
	);

	rsa_rail_decode #(.W(4), .BACKUP(1'b0)) u_lr (
		.code(switch_regulator_strobe_select[`RSA_LR_HI:`RSA_LR_LO]),
		.strobe(strobe),
		.strobe_valid(strobe_valid),
		.up(up),
		.seal_broken(seal_sync),
		.cmd(cmd[3])
	);

	// Command pulses last one cycle; the sequencer counts the steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail_enable <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				rail_enable[i] <= cmd[i].enable;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail_disable <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				rail_disable[i] <= cmd[i].turn_off;
			end
		end
	end
endmodule

// *** dv/rsa_top_properties.sv ***
// Checker for the strobe assignment block
`timescale 1ns/100ps
module rsa_top_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] strobe,
	input wire logic strobe_valid,
	input wire logic freshness_seal_flag,
	input wire logic [3:0] rail_enable,
	input wire logic [3:0] rail_disable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wt; psel && penable && !pready |=> pready; endproperty
	a_wt: assert property (p_wt) else $error("late ready");
	property p_pl; pready |=> !pready; endproperty
	a_pl: assert property (p_pl) else $error("ready held");
	property p_rz; pready |-> prdata[31:8] == 0; endproperty
	a_rz: assert property (p_rz) else $error("upper bits");
	property p_er; pslverr |-> pready && prdata == 0; endproperty
	a_er: assert property (p_er) else $error("bad error");
	property p_se; freshness_seal_flag [*5] |-> !rail_enable[1:0]; endproperty
	a_se: assert property (p_se) else $error("sealed on");
	property p_sd; freshness_seal_flag [*5] |-> !rail_disable[1:0]; endproperty
	a_sd: assert property (p_sd) else $error("sealed off");
	property p_sv; |rail_enable |-> $past(strobe_valid); endproperty
	a_sv: assert property (p_sv) else $error("no step");
	property p_hi; |rail_enable[3:2] |-> $past(strobe) inside {[3:10]};
	endproperty
	a_hi: assert property (p_hi) else $error("bad strobe");
	c_er: cover property (pslverr);
	c_en: cover property (|rail_enable);
	c_bk: cover property (|rail_enable[1:0]);
	c_dn: cover property (|rail_disable);
endmodule
bind rsa_top rsa_top_properties u_rsa_top_properties (.*);

// *** dv/rsa_top_tb.sv ***
// Self-checking bench for the strobe assignment block
`timescale 1ns/100ps
module rsa_top_tb;
	import rsa_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic strobe_valid, freshness_seal_flag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, strobe, rail_enable, rail_disable, en, dis;
	rsa_dir_e dir;
	int bad_count, compares;
	// Switch/regulator codes, strobe, expected enables
	logic [15:0] rows [6] = '{16'hA7A4, 16'hA778, 16'h3B34, 16'h2AA8,
		16'hB222, 16'h3311};
	rsa_top u_rsa_top (.*);
	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end
	task chk(string n, logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 0;
	endtask
	// Unlock covers just the next write
	task uw(logic [11:0] a, logic [31:0] d);
		apb(1, 12'h098, 32'h7D);
		apb(1, a, d);
	endtask
	task stb(logic [3:0] s, rsa_dir_e d);
		@(posedge pclk);
		strobe <= s;
		dir <= d;
		strobe_valid <= 1'b1;
		@(posedge pclk);
		strobe_valid <= 0;
		{en, dis} = 0;
		repeat (3) begin
			@(posedge pclk);
			en |= rail_enable;
			dis |= rail_disable;
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, strobe_valid, freshness_seal_flag} = 0;
		{paddr, pwdata, strobe} = 0;
		dir = RSA_IDLE;
		pstrb = 4'hF;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h090, 0);
		chk("bk rst", rd, 32'h12);
		apb(0, 12'h094, 0);
		chk("sw rst", rd, 32'hA7);
		foreach (rows[i]) begin
			uw(12'h094, {24'h00_0000, rows[i][15:8]});
			stb(rows[i][7:4], RSA_UP);
			chk("enable", en, rows[i][3:0]);
		end
		apb(1, 12'h094, 32'h55);
		apb(0, 12'h094, 0);
		chk("locked", rd, 32'h33);
		uw(12'h090, 32'hFF);
		apb(0, 12'h090, 0);
		chk("reserved", rd, 32'h33);
		apb(0, 12'h100, 0);
		chk("unmapped", er, 1);
		uw(12'h090, 32'h21);
		stb(1, RSA_UP);
		chk("rail5 s1", en, 4'h2);
		stb(2, RSA_DOWN);
		chk("rail6 off", dis, 4'h1);
		stb(3, RSA_DOWN);
		chk("sw off", dis, 4'hC);
		freshness_seal_flag <= 1;
		repeat (3) @(posedge pclk);
		stb(1, RSA_UP);
		chk("sealed", en, 0);
		stb(2, RSA_DOWN);
		chk("sealed off", dis, 0);
		apb(0, 12'h09C, 0);
		chk("status", rd, 32'h2);
		presetn <= 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h090, 0);
		chk("bk rst2", rd, 32'h12);
		apb(0, 12'h094, 0);
		chk("sw rst2", rd, 32'hA7);
		wrap_up;
	end
	initial begin
		#200000;
		bad_count++;
		wrap_up;
	end
endmodule
